//--- timer_counter_pwm_capture.sv
// Purpose: 16-bit up/down timer with compare, pwm, capture and interrupts
// Assumes: one clock, synchronous active-high rst, pins async to clk
// Notes: bus_mode low gives stand-alone operation on preloaded settings
`timescale 1ns/1ps
module timer_counter_pwm_capture (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic timer_clock_in,
    input wire logic timer_direct_reset_n,
    input wire logic capture_trigger_in,
    output logic timer_interrupt_out,
    output logic timer_wakeup_out,
    output logic timer_waveform_out,
    // operating selection
    input wire logic bus_mode,
    input wire timer_pkg::timer_mode_e mode,
    input wire logic clk_src,
    input wire logic [timer_pkg::PRE_W-1:0] pre_sel,
    input wire logic direct_reset_pin_enable,
    input wire logic wakeup_enable,
    // compare settings
    input wire logic [timer_pkg::CNT_W-1:0] top_value,
    input wire logic [timer_pkg::CNT_W-1:0] compare_value,
    input wire logic out_invert,
    // interrupt control
    input wire logic capture_enable,
    input wire logic [2:0] irq_enable,
    input wire logic [2:0] irq_clear,
    // status
    output logic [timer_pkg::CNT_W-1:0] running_count_value,
    output logic [timer_pkg::CNT_W-1:0] capture_timestamp_reg,
    output logic [2:0] irq_status,
    output logic count_down
);

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic ext_clk_sync;             // synced external clock
    logic rst_n_sync;               // synced direct reset, active low
    logic cap_sync;                 // synced capture trigger
    logic cap_prev;                 // last capture level
    logic tick;                     // prescaled count tick
    logic direct_clear;             // direct reset pin asserted
    logic is_pwm;                   // pwm mode selected
    logic [timer_pkg::CNT_W-1:0] top;      // effective top
    logic at_top;                   // count equals top
    logic at_bottom;                // count equals zero
    logic at_cmp;                   // count equals compare
    logic ovf_ev;                   // overflow event
    logic cmp_ev;                   // compare match event
    logic cap_ev;                   // capture event
    logic [2:0] set_ev;             // events by flag position
    logic [timer_pkg::CNT_W-1:0] next_count;  // count after tick
    logic next_down;                // direction after tick
    logic [timer_pkg::CNT_W-1:0] cmp_buf;     // double-buffered compare
    logic [timer_pkg::CNT_W-1:0] top_buf;     // double-buffered top
    logic next_wave;                // waveform after tick

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    timer_sync u_sync_clk (
        .clk(clk),
        .rst(rst),
        .async_in(timer_clock_in),
        .reset_level(1'b0),
        .sync_out(ext_clk_sync)
    );

    // active low pin: chain resets high, its idle level
    timer_sync u_sync_rst (
        .clk(clk),
        .rst(rst),
        .async_in(timer_direct_reset_n),
        .reset_level(1'b1),
        .sync_out(rst_n_sync)
    );

    timer_sync u_sync_cap (
        .clk(clk),
        .rst(rst),
        .async_in(capture_trigger_in),
        .reset_level(1'b0),
        .sync_out(cap_sync)
    );

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    timer_prescaler u_pre (
        .clk(clk),
        .rst(rst),
        .clk_src(clk_src),
        .pre_sel(pre_sel),
        .ext_clk_sync(ext_clk_sync),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    // direct reset acts whenever its enable is set, in bus and standalone mode alike
    assign direct_clear = direct_reset_pin_enable & ~rst_n_sync;
    assign is_pwm = (mode == timer_pkg::mode_fast_pwm) | (mode == timer_pkg::mode_pfc_pwm);
    // watchdog uses full range, others the buffered top
    assign top = (mode == timer_pkg::mode_watchdog) ? timer_pkg::TOP_MAX : top_buf;
    assign at_top = (running_count_value == top);
    assign at_bottom = (running_count_value == timer_pkg::CNT_RESET);
    assign at_cmp = (running_count_value == cmp_buf);

    // overflow: wrap at top, or bottom turn in dual slope; none in ctc
    assign ovf_ev = tick & ((mode == timer_pkg::mode_pfc_pwm) ? (count_down & at_bottom)
                    : (mode == timer_pkg::mode_ctc) ? 1'b0 : at_top);
    assign cmp_ev = tick & at_cmp;
    // capture: rising edge, enabled, bus present, non-pwm
    assign cap_ev = capture_enable & bus_mode & ~is_pwm & cap_sync & ~cap_prev;
    assign set_ev = {cap_ev, cmp_ev, ovf_ev};

    // ------------------------------------------------------------------
    // next count and direction
    // ------------------------------------------------------------------
    always_comb begin
        next_count = running_count_value;
        next_down = count_down;
        unique case (mode)
            timer_pkg::mode_pfc_pwm: begin
                // dual slope: turn at top and at zero
                if (!count_down && at_top) begin
                    next_down = 1'b1;
                    next_count = running_count_value - 16'h0001;
                end else if (count_down && at_bottom) begin
                    next_down = 1'b0;
                    next_count = running_count_value + 16'h0001;
                end else begin
                    next_count = count_down ? running_count_value - 16'h0001
                                            : running_count_value + 16'h0001;
                end
            end
            timer_pkg::mode_ctc: begin
                // back to zero on the tick that meets compare
                next_down = 1'b0;
                next_count = at_cmp ? timer_pkg::CNT_RESET
                                    : running_count_value + 16'h0001;
            end
            default: begin
                // watchdog and fast pwm reload at top
                next_down = 1'b0;
                next_count = at_top ? timer_pkg::CNT_RESET
                                    : running_count_value + 16'h0001;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // waveform
    // ------------------------------------------------------------------
    always_comb begin
        next_wave = timer_waveform_out;
        unique case (mode)
            timer_pkg::mode_fast_pwm: begin
                // set at period start, clear at match
                if (at_top) next_wave = ~out_invert;
                else if (at_cmp) next_wave = out_invert;
            end
            timer_pkg::mode_pfc_pwm: begin
                if (at_cmp) next_wave = count_down ? ~out_invert : out_invert;
            end
            default: begin
                // non-pwm: toggle on compare match
                if (at_cmp) next_wave = ~timer_waveform_out;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // counter, buffers and waveform register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || direct_clear) begin
            running_count_value <= timer_pkg::CNT_RESET;
            count_down <= 1'b0;
            timer_waveform_out <= 1'b0;
            cmp_buf <= compare_value;
            top_buf <= top_value;
        end else if (tick) begin
            running_count_value <= next_count;
            count_down <= next_down;
            timer_waveform_out <= next_wave;
            // pwm modes update settings only at top or at the dual-slope bottom turn so no glitch; other modes every tick
            if ((!is_pwm) || at_top || (count_down && at_bottom)) begin
                cmp_buf <= compare_value;
                top_buf <= top_value;
            end
        end
    end

    // ------------------------------------------------------------------
    // capture register and edge history
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_prev <= 1'b0;
            capture_timestamp_reg <= timer_pkg::CNT_RESET;
        end else begin
            cap_prev <= cap_sync;
            if (cap_ev) capture_timestamp_reg <= running_count_value;
        end
    end

    // ------------------------------------------------------------------
    // sticky flags: set wins over clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | set_ev;
        end
    end

    // ------------------------------------------------------------------
    // interrupt outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_interrupt_out <= 1'b0;
            timer_wakeup_out <= 1'b0;
        end else begin
            // bus: masked flags; no bus: overflow flag alone
            timer_interrupt_out <= bus_mode ? |(irq_status & irq_enable)
                                            : irq_status[0];
            timer_wakeup_out <= wakeup_enable & |(irq_status & irq_enable);
        end
    end

endmodule

//--- timer_pkg.sv
// Purpose: shared constants and types for the timer/counter with compare and capture
// Assumes: 16-bit count, one system clock at 200 MHz
// Notes: mode codes, clock source codes and reset values live here
package timer_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int CNT_W = 16;          // counter width
    localparam int PRE_W = 3;           // prescaler select width
    localparam int DIV_W = 10;          // prescaler divider width

    // ------------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        mode_watchdog = 2'h0,           // free count, overflow wraps
        mode_ctc      = 2'h1,           // clear on compare match
        mode_fast_pwm = 2'h2,           // single slope pwm
        mode_pfc_pwm  = 2'h3            // dual slope pwm
    } timer_mode_e;

    // ------------------------------------------------------------------
    // clock sources
    // ------------------------------------------------------------------
    localparam logic CLK_SRC_SYS = 1'h0;    // system clock ticks
    localparam logic CLK_SRC_PIN = 1'h1;    // external clock rising edges

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;  // count after reset
    localparam logic [CNT_W-1:0] TOP_MAX = 16'hffff;    // full range top
    localparam logic [DIV_W-1:0] DIV_RESET = 10'h000;   // prescaler after reset
    localparam int SYNC_STAGES = 2;                     // synchroniser depth

endpackage

//--- timer_prescaler.sv
// Purpose: choose the count clock source and divide it into count ticks
// Assumes: external clock input is already synchronised by the caller
// Notes: select 0 stops the counter; 1..7 divide by 1,8,32,64,128,256,1024
`timescale 1ns/1ps
module timer_prescaler (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic clk_src,
    input wire logic [timer_pkg::PRE_W-1:0] pre_sel,
    // synchronised external clock
    input wire logic ext_clk_sync,
    // count tick out
    output logic tick
);

    logic ext_prev;                             // last external clock level
    logic src_pulse;                            // raw source pulse
    logic [timer_pkg::DIV_W-1:0] div;           // divider counter
    logic [timer_pkg::DIV_W-1:0] div_last;      // terminal count of divider
    logic div_end;                              // divider at terminal

    // ------------------------------------------------------------------
    // source choice
    // ------------------------------------------------------------------
    assign src_pulse = (clk_src == timer_pkg::CLK_SRC_PIN) ? (ext_clk_sync & ~ext_prev) : 1'b1;

    // divide ratio minus one per select code
    assign div_last = (pre_sel == 3'h2) ? 10'h007 :
                      (pre_sel == 3'h3) ? 10'h01f :
                      (pre_sel == 3'h4) ? 10'h03f :
                      (pre_sel == 3'h5) ? 10'h07f :
                      (pre_sel == 3'h6) ? 10'h0ff :
                      (pre_sel == 3'h7) ? 10'h3ff : 10'h000;
    assign div_end = (div >= div_last);
    assign tick = (pre_sel != 3'h0) & src_pulse & div_end;

    // ------------------------------------------------------------------
    // divider and edge history
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_prev <= 1'b0;
            div <= timer_pkg::DIV_RESET;
        end else begin
            ext_prev <= ext_clk_sync;
            if (pre_sel == 3'h0) begin
                div <= timer_pkg::DIV_RESET;    // stopped: hold divider clear
            end else if (src_pulse) begin
                div <= div_end ? timer_pkg::DIV_RESET : div + 10'h001;
            end
        end
    end

endmodule

//--- timer_sync.sv
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input is asynchronous to clk
// Notes: only the second stage is visible to logic
`timescale 1ns/1ps
module timer_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // async level in, synced level out
    input wire logic async_in,
    input wire logic reset_level,
    output logic sync_out
);

    logic [timer_pkg::SYNC_STAGES-1:0] stage;   // shift chain

    // ------------------------------------------------------------------
    // chain; resets to the pin's idle level
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            stage <= {timer_pkg::SYNC_STAGES{reset_level}};
        end else begin
            stage <= {stage[0], async_in};
        end
    end

    // only the last stage is read, so no logic sees a metastable level
    assign sync_out = stage[timer_pkg::SYNC_STAGES-1];

endmodule

//--- timer_counter_pwm_capture_props.sv
// Purpose: port-level checks for the timer/counter
// Assumes: one clock, synchronous active-high rst
// Notes: settle counts quiet cycles after a count setting change or a low direct reset pin
`timescale 1ns/1ps
module timer_counter_pwm_capture_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic timer_direct_reset_n,
    input wire logic timer_interrupt_out,
    input wire logic timer_wakeup_out,
    // settings
    input wire logic bus_mode,
    input wire timer_pkg::timer_mode_e mode,
    input wire logic clk_src,
    input wire logic [timer_pkg::PRE_W-1:0] pre_sel,
    input wire logic wakeup_enable,
    input wire logic [timer_pkg::CNT_W-1:0] top_value,
    input wire logic [timer_pkg::CNT_W-1:0] compare_value,
    input wire logic capture_enable,
    input wire logic [2:0] irq_enable,
    input wire logic [2:0] irq_clear,
    // status
    input wire logic [timer_pkg::CNT_W-1:0] running_count_value,
    input wire logic [timer_pkg::CNT_W-1:0] capture_timestamp_reg,
    input wire logic [2:0] irq_status
);
    // ----------
    // helper logic
    // ----------
    wire [37:0] cfg = {pre_sel, mode, clk_src, top_value, compare_value}; // count settings: prescale, mode, source, top, compare
    logic [37:0] cfg_prev; // settings one cycle ago
    logic [2:0] settle; // quiet cycles, saturates at 7
    logic [2:0] cap_off; // cycles capture was refused
    logic exp_int; // expected interrupt level
    logic exp_wake; // expected wake-up level
    wire disturb = !timer_direct_reset_n || cfg != cfg_prev;
    wire [2:0] masked = irq_status & irq_enable;
    wire nonpwm = mode == timer_pkg::mode_watchdog || mode == timer_pkg::mode_ctc;
    wire cap_ok = bus_mode && capture_enable && nonpwm;
    wire run1 = settle == 3'h7 && pre_sel == 3'h1 && clk_src == timer_pkg::CLK_SRC_SYS;
    // track quiet time and registered interrupt expectations
    always_ff @(posedge clk) begin
        cfg_prev <= cfg;
        exp_int <= !rst && (bus_mode ? |masked : irq_status[0]);
        exp_wake <= !rst && wakeup_enable && |masked;
        settle <= (rst || disturb) ? 3'h0 : settle + {2'h0, settle != 3'h7};
        cap_off <= (rst || cap_ok) ? 3'h0 : cap_off + {2'h0, cap_off != 3'h7};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------
    // properties
    // ----------
    property p_stop;
        settle == 3'h7 && pre_sel == 3'h0 |=> $stable(running_count_value);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    property p_step;
        run1 && mode == timer_pkg::mode_watchdog && running_count_value != 16'hffff
            |=> running_count_value == $past(running_count_value) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count did not step by one");
    property p_wrap;
        run1 && mode == timer_pkg::mode_watchdog && running_count_value == 16'hffff
            |=> running_count_value == 16'h0000 ##[0:1] irq_status[0];
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap with overflow flag");
    property p_ctc;
        run1 && mode == timer_pkg::mode_ctc && running_count_value == compare_value
            |=> running_count_value == 16'h0000;
    endproperty
    a_ctc: assert property (p_ctc) else $error("count not cleared after match");
    property p_clear;
        settle == 3'h7 && pre_sel == 3'h0 && irq_clear[0] |=> !irq_status[0];
    endproperty
    a_clear: assert property (p_clear) else $error("overflow flag not cleared");
    property p_int;
        timer_interrupt_out == exp_int;
    endproperty
    a_int: assert property (p_int) else $error("interrupt line wrong");
    property p_wake;
        timer_wakeup_out == exp_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up line wrong");
    property p_cap_hold;
        cap_off == 3'h7 |=> $stable(capture_timestamp_reg);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture while refused");
endmodule

bind timer_counter_pwm_capture timer_counter_pwm_capture_props u_props (
    .clk, .rst, .timer_direct_reset_n, .timer_interrupt_out, .timer_wakeup_out,
    .bus_mode, .mode, .clk_src, .pre_sel, .wakeup_enable, .top_value, .compare_value,
    .capture_enable, .irq_enable, .irq_clear, .running_count_value,
    .capture_timestamp_reg, .irq_status
);

//--- timer_pin_source.sv
// Purpose: far-side pin source, external count clock and capture trigger
// Assumes: bench requests change on the falling edge
// Notes: the count clock stands low whenever it is not asked to run
`timescale 1ns/1ps
module timer_pin_source (
    // clock
    input wire logic clk,
    // requests
    input wire logic ext_run,
    input wire logic cap_req,
    // pins
    output logic ext_pin,
    output logic cap_pin
);
    logic [3:0] div = 4'h0; // phase of the pin clock, period ten cycles
    logic [3:0] hold = 4'h0; // trigger pulse timer
    assign ext_pin = div >= 4'h5; // one rising edge per period
    assign cap_pin = hold > 4'h4; // high five cycles, then low at least four
    // advance the pin clock and the trigger pulse
    always @(posedge clk) begin
        div <= (ext_run && div != 4'h9) ? div + 4'h1 : 4'h0;
        hold <= (cap_req && hold == 4'h0) ? 4'h9 : hold - {3'h0, hold != 4'h0};
    end
endmodule

//--- test_timer_counter_pwm_capture.sv
// Purpose: self-checking bench for the timer/counter
// Assumes: inputs change on the falling clock edge
// Notes: capture results checked from a queue by a watcher process
`timescale 1ns/1ps
module test_timer_counter_pwm_capture;
    logic clk = 1'b0, rst = 1'b1, timer_direct_reset_n = 1'b1, bus_mode = 1'b0;
    logic clk_src = 1'b0, direct_reset_pin_enable = 1'b1, wakeup_enable = 1'b0;
    logic out_invert = 1'b0, capture_enable = 1'b0, ext_run = 1'b0, cap_req = 1'b0;
    logic timer_clock_in, capture_trigger_in, timer_interrupt_out, timer_wakeup_out;
    logic timer_waveform_out, count_down;
    timer_pkg::timer_mode_e mode = timer_pkg::mode_watchdog;
    logic [2:0] pre_sel = 3'h0, irq_enable = 3'h0, irq_clear = 3'h0, irq_status;
    logic [15:0] top_value = 16'h0010, compare_value = 16'h0008;
    logic [15:0] running_count_value, capture_timestamp_reg, max_cnt;
    logic [15:0] cap_q[$]; // expected capture values
    int miscompares = 0, total_checks = 0, wave_hi, down_hi;
    int ratio[8] = '{0, 1, 8, 32, 64, 128, 256, 1024}; // prescaler divide table
    always #2.5 clk = ~clk;
    timer_counter_pwm_capture u_dut (.clk, .rst, .timer_clock_in, .timer_direct_reset_n,
        .capture_trigger_in, .timer_interrupt_out, .timer_wakeup_out, .timer_waveform_out,
        .bus_mode, .mode, .clk_src, .pre_sel, .direct_reset_pin_enable, .wakeup_enable,
        .top_value, .compare_value, .out_invert, .capture_enable, .irq_enable, .irq_clear,
        .running_count_value, .capture_timestamp_reg, .irq_status, .count_down);
    timer_pin_source u_pins (.clk, .ext_run, .cap_req, .ext_pin(timer_clock_in),
        .cap_pin(capture_trigger_in));
    // ----------
    // shared tasks
    // ----------
    task automatic final_report();
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // cycles until the count next changes, bounded
    task automatic gap(output int n);
        logic [15:0] v;
        v = running_count_value;
        n = 0;
        while (running_count_value === v) begin
            if (n == 3000) begin miscompares++; final_report(); end
            @(negedge clk);
            n++;
        end
    endtask
    // count peak, waveform highs and down-count cycles
    task automatic watch(input int n);
        max_cnt = 16'h0000;
        wave_hi = 0;
        down_hi = 0;
        repeat (n) begin
            @(negedge clk);
            if (running_count_value > max_cnt) max_cnt = running_count_value;
            wave_hi += int'(timer_waveform_out);
            down_hi += int'(count_down);
        end
    endtask
    task automatic pin_clear();
        timer_direct_reset_n = 1'b0;
        repeat (5) @(negedge clk);
        check("direct_clear", 16'h0000, running_count_value);
        timer_direct_reset_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic pulse(input logic [2:0] clr);
        irq_clear = clr;
        cap_req = 1'b1;
        @(negedge clk);
        irq_clear = 3'h0;
        cap_req = 1'b0;
        repeat (16) @(negedge clk);
    endtask
    // watcher: every capture change takes the oldest note
    initial begin
        logic [15:0] exp;
        @(negedge rst);
        forever begin
            @(capture_timestamp_reg);
            #1;
            exp = (cap_q.size() != 0) ? cap_q.pop_front() : ~capture_timestamp_reg;
            check("capture", exp, capture_timestamp_reg);
        end
    end
    // ----------
    // main sequence
    // ----------
    initial begin
        int n;
        int k;
        logic [15:0] top;
        logic [15:0] cmp;
        void'($urandom(32'h0a1c8b15));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        check("reset_count", 16'h0000, running_count_value);
        for (int s = 1; s < 8; s++) begin
            pre_sel = s[2:0];
            gap(n);
            gap(n);
            check("tick_gap", ratio[s][15:0], n[15:0]);
        end
        pre_sel = 3'h1;
        n = 0;
        while (irq_status[0] !== 1'b1) begin
            if (n++ == 70000) begin miscompares++; final_report(); end
            @(negedge clk);
        end
        repeat (2) @(negedge clk);
        check("wrapped", 16'h0001, {15'h0, running_count_value < 16'h0008});
        check("overflow_int", 16'h0001, {15'h0, timer_interrupt_out});
        pin_clear();
        irq_clear = 3'h2;
        @(negedge clk);
        irq_clear = 3'h0;
        cmp = 16'h0002 + 16'($urandom % 8);
        compare_value = cmp;
        mode = timer_pkg::mode_ctc;
        watch(60);
        check("ctc_peak", cmp, max_cnt);
        check("ctc_flag", 16'h0001, {15'h0, irq_status[1]});
        bus_mode = 1'b1;
        for (int i = 0; i < 3; i++) begin
            irq_enable = (i == 1) ? 3'h0 : 3'h2;
            wakeup_enable = (i != 2);
            repeat (2) @(negedge clk);
            check("int_line", {15'h0, i != 1}, {15'h0, timer_interrupt_out});
            check("wake_line", {15'h0, i == 0}, {15'h0, timer_wakeup_out});
        end
        pre_sel = 3'h0;
        repeat (9) @(negedge clk);
        pulse(3'h3);
        check("flag_cleared", 16'h0000, {13'h0, irq_status[1:0], 1'b0});
        pre_sel = 3'h1;
        top = 16'h0004 + 16'($urandom % 16);
        cmp = 16'($urandom % top);
        top_value = top;
        compare_value = cmp;
        pin_clear();
        mode = timer_pkg::mode_fast_pwm;
        for (int inv = 0; inv < 2; inv++) begin
            out_invert = inv[0];
            repeat (2 * (top + 1)) @(negedge clk);
            watch(8 * (top + 1));
            check("pwm_peak", top, max_cnt);
            check("pwm_high", inv ? 8 * (top - cmp) : 8 * (cmp + 1), wave_hi[15:0]);
        end
        mode = timer_pkg::mode_pfc_pwm;
        repeat (4 * top) @(negedge clk);
        watch(8 * top);
        check("dual_peak", top, max_cnt);
        check("dual_down", 16'h0001, {15'h0, down_hi != 0});
        mode = timer_pkg::mode_watchdog;
        clk_src = timer_pkg::CLK_SRC_PIN;
        capture_enable = 1'b1;
        for (int i = 0; i < 3; i++) begin
            k = 3 + 7 * i + int'($urandom % 5);
            pin_clear();
            ext_run = 1'b1;
            repeat (10 * k) @(negedge clk);
            ext_run = 1'b0;
            repeat (6) @(negedge clk);
            check("pin_edges", k[15:0], running_count_value);
            cap_q.push_back(k[15:0]);
            pulse(3'h0);
        end
        check("capture_flag", 16'h0001, {15'h0, irq_status[2]});
        pin_clear();
        for (int j = 0; j < 3; j++) begin
            capture_enable = (j != 0);
            bus_mode = (j != 1);
            mode = (j == 2) ? timer_pkg::mode_fast_pwm : timer_pkg::mode_watchdog;
            repeat (9) @(negedge clk);
            pulse(3'h0);
            check("capture_refused", k[15:0], capture_timestamp_reg);
        end
        check("capture_pending", 16'h0000, 16'(cap_q.size()));
        final_report();
    end
endmodule
